// *** irqpf_params.svh ***
// constants for the interrupt flag and priority block: register indexes, field
// positions, reset values, level codes and timing counts
// assumes a word-addressed bus: byte address is four times the index
`ifndef IRQPF_PARAMS_SVH
`define IRQPF_PARAMS_SVH

// register indexes (byte address = index * 4)
`define IRQPF_EXT_FLAGS_IDX 10'h091
`define IRQPF_BASE_EN_IDX 10'h0a8
`define IRQPF_BASE_PRIO_IDX 10'h0b8
`define IRQPF_EXT_CTRL_IDX 10'h0d8
`define IRQPF_EXT_EN_IDX 10'h0e8
`define IRQPF_EXT_PRIO_IDX 10'h0f8
`define IRQPF_SENSE_IDX 10'h100
`define IRQPF_STAT_IDX 10'h101
`define IRQPF_MASK_IDX 10'h102
`define IRQPF_WIN_IDX 10'h103

// extended flag register fields
`define IRQPF_TIMER3_BIT 7
`define IRQPF_CONV_BIT 6
`define IRQPF_TIMER2_BIT 5
`define IRQPF_RADIO_BIT 4
`define IRQPF_EXT_FLAGS_FIXED 8'h08
// extended control register fields
`define IRQPF_FD_EN_BIT 5
`define IRQPF_FD_FLAG_BIT 4
`define IRQPF_RTC_FLAG_BIT 3
`define IRQPF_EXT_CTRL_FIXED 8'h40
// global enable position in base enable register
`define IRQPF_GLOBAL_BIT 7
// read-as-one bits of priority and enable registers
`define IRQPF_BASE_PRIO_FIXED 8'h80
`define IRQPF_EXT_PRIO_FIXED 8'he0
`define IRQPF_EXT_EN_FIXED 8'he0
`define IRQPF_RESET_BYTE 8'h00

// level codes
`define IRQPF_LVL_NONE 2'h0
`define IRQPF_LVL_LOW 2'h1
`define IRQPF_LVL_HIGH 2'h2
`define IRQPF_LVL_TOP 2'h3

// least external pulse always caught, in clock cycles
`define IRQPF_EXT_MIN_PULSE 8

`endif

// *** irqpf_pkg.sv ***
// types shared by the interrupt flag and priority block
// assumes irqpf_params.svh supplies the numeric constants
package irqpf_pkg;
   typedef logic [1:0] irqpf_lvl_t;   // priority level code
   typedef logic [3:0] irqpf_id_t;    // source number, natural order
   typedef logic [7:0] irqpf_byte_t;  // one register byte
endpackage

// *** irqpf_ctrl.sv ***
// interrupt flag collection, priority registers and two-stage arbitration
// assumes an apb master on pclk and a core that acks the presented source
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "irqpf_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - timer 3 request sets flag bit 7
// - converter or cipher sets shared bit 6
// - each needs its own local enable
// - timer 2 request sets flag bit 5
// - radio request sets flag bit 4
// - compare level first, then natural order
// - level always beats natural order
// - only flash/debug reaches highest level
// - priority bit 0 low, 1 high
// - equal level: lowest number served first
// - only strictly higher level preempts service
// - base priority bit layout fixed
// - extended priority bit layout fixed
// - two external pins, level or edge
// - pulse over 8 cycles always requests
// - global enable spares only flash/debug
// - extra instruction after return or write
module irqpf_ctrl
   import irqpf_pkg::*;
#(
   parameter int ADDR_W = 12 // apb byte address width
) (
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic [ADDR_W-1:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped index
   input wire logic timer0_req, // timer 0 request level
   input wire logic timer1_req, // timer 1 request level
   input wire logic serial0_req, // serial 0 request level
   input wire logic serial1_req, // serial 1 request level
   input wire logic timer2_req, // timer 2 request
   input wire logic timer3_req, // timer 3 request
   input wire logic radio_req, // transceiver request
   input wire logic rtclock_req, // real-time clock request
   input wire logic flashdbg_req, // flash write done or trap
   input wire logic converter_done_flag, // converter completion
   input wire logic converter_local_enable, // converter own enable
   input wire logic cipher_done_flag, // cipher completion
   input wire logic cipher_local_enable, // cipher own enable
   input wire logic ext0_pin_n, // external pin 0, active low
   input wire logic ext1_pin_n, // external pin 1, active low
   input wire logic core_ack, // core takes presented source
   input wire logic core_reti, // core returned from service
   input wire logic core_instr_done, // instruction completed
   input wire logic core_instr_special, // it was a return or enable/prio write
   output logic irq_req, // a winner is presented
   output irqpf_id_t irq_id, // winning source number
   output irqpf_lvl_t irq_level, // winning level
   output logic irq // summary interrupt, masked status
);

   localparam int NSRC = 12; // flash/debug plus eleven sources

   ////////////////////////////////////////////////////////////////////////////////
   // register state
   irqpf_byte_t ext_flags_q, ext_flags_d; // extended flag bits
   irqpf_byte_t base_en_q; // base enable with global bit
   irqpf_byte_t base_prio_q; // base priority
   irqpf_byte_t ext_ctrl_q, ext_ctrl_d; // extended control with flags
   irqpf_byte_t ext_en_q; // extended enable
   irqpf_byte_t ext_prio_q; // extended priority
   logic [1:0] sense_q; // bit 0 ext0, bit 1 ext1: 1 edge
   logic [5:0] stat_q, stat_d; // sticky event status
   logic [5:0] mask_q; // status mask
   logic [31:0] prdata_q; // registered read data
   logic pready_q; // registered ready
   logic pslverr_q; // registered error
   logic irq_q; // registered summary
   logic irq_req_q, irq_req_d; // presented winner valid
   irqpf_id_t irq_id_q, irq_id_d; // presented winner
   irqpf_lvl_t irq_level_q, irq_level_d; // presented level
   logic [3:1] isr_q, isr_d; // in-service bit per level
   logic defer_q; // one more instruction pending
   logic [5:0] req_prev_q; // previous hardware request levels
   logic [1:0] ext_s1_q, ext_s2_q, ext_s3_q; // pin synchronisers
   logic [1:0] ext_stable_q, ext_stable_d; // agreed pin levels
   logic [1:0] ext_edge_q, ext_edge_d; // latched edge requests

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire [9:0] idx = paddr[ADDR_W-1:2];
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready_q & pwrite;
   wire hit_flags = (idx == `IRQPF_EXT_FLAGS_IDX);
   wire hit_ben = (idx == `IRQPF_BASE_EN_IDX);
   wire hit_bprio = (idx == `IRQPF_BASE_PRIO_IDX);
   wire hit_ctrl = (idx == `IRQPF_EXT_CTRL_IDX);
   wire hit_een = (idx == `IRQPF_EXT_EN_IDX);
   wire hit_eprio = (idx == `IRQPF_EXT_PRIO_IDX);
   wire hit_sense = (idx == `IRQPF_SENSE_IDX);
   wire hit_stat = (idx == `IRQPF_STAT_IDX);
   wire hit_mask = (idx == `IRQPF_MASK_IDX);
   wire hit_win = (idx == `IRQPF_WIN_IDX);
   wire hit_any = hit_flags | hit_ben | hit_bprio | hit_ctrl | hit_een | hit_eprio |
      hit_sense | hit_stat | hit_mask | hit_win;
   wire [7:0] wb = pwdata[7:0];

   // read mux, reserved bits forced to their fixed values
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_flags) begin
         rd_mux[7:0] = {ext_flags_q[7:4], 4'h0} | `IRQPF_EXT_FLAGS_FIXED;
      end else if (hit_ben) begin
         rd_mux[7:0] = base_en_q;
      end else if (hit_bprio) begin
         rd_mux[7:0] = base_prio_q | `IRQPF_BASE_PRIO_FIXED;
      end else if (hit_ctrl) begin
         rd_mux[7:0] = {ext_ctrl_q[7], 1'b0, ext_ctrl_q[5:3], 3'h0} | `IRQPF_EXT_CTRL_FIXED;
      end else if (hit_een) begin
         rd_mux[7:0] = {3'h0, ext_en_q[4:0]} | `IRQPF_EXT_EN_FIXED;
      end else if (hit_eprio) begin
         rd_mux[7:0] = {3'h0, ext_prio_q[4:0]} | `IRQPF_EXT_PRIO_FIXED;
      end else if (hit_sense) begin
         rd_mux[1:0] = sense_q;
      end else if (hit_stat) begin
         rd_mux[5:0] = stat_q;
      end else if (hit_mask) begin
         rd_mux[5:0] = mask_q;
      end else if (hit_win) begin
         rd_mux[10:0] = {isr_q, irq_req_q, irq_level_q, 1'b0, irq_id_q};
      end
   end

   // answer one cycle after setup: zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         if (setup) begin
            prdata_q <= rd_mux;
            pslverr_q <= ~hit_any;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // external pins: three flops, change counts when second and third agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_q <= 2'h3;
         ext_s2_q <= 2'h3;
         ext_s3_q <= 2'h3;
      end else begin
         ext_s1_q <= {ext1_pin_n, ext0_pin_n};
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // agreed level; a falling agreed level latches an edge request
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ext_stable_d[i] = (ext_s2_q[i] == ext_s3_q[i]) ? ext_s3_q[i] : ext_stable_q[i];
         ext_edge_d[i] = ext_edge_q[i];
         // the core's acceptance clears the edge latch, a new edge wins
         if (core_ack && irq_id_q == irqpf_id_t'(2 * i + 1)) begin
            ext_edge_d[i] = 1'b0;
         end
         if (ext_stable_q[i] && !ext_stable_d[i]) begin
            ext_edge_d[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_stable_q <= 2'h3;
         ext_edge_q <= 2'h0;
      end else begin
         ext_stable_q <= ext_stable_d;
         ext_edge_q <= ext_edge_d;
      end
   end

   // sense select: edge latch or live low level
   wire [1:0] ext_req = (sense_q & ext_edge_q) | (~sense_q & ~ext_stable_q);

   ////////////////////////////////////////////////////////////////////////////////
   // hardware-set flags: rising request sets, set wins over software write
   wire conv_cipher_req = (converter_done_flag & converter_local_enable) |
      (cipher_done_flag & cipher_local_enable);
   wire [5:0] hw_lvl = {flashdbg_req, rtclock_req, timer3_req, conv_cipher_req, timer2_req, radio_req};
   wire [5:0] hw_set = hw_lvl & ~req_prev_q; // one pulse per request
   wire wr_flags = wr_en & hit_flags;
   wire wr_ctrl = wr_en & hit_ctrl;

   always_comb begin
      ext_flags_d = ext_flags_q;
      ext_ctrl_d = ext_ctrl_q;
      if (wr_flags) begin
         ext_flags_d[7:4] = wb[7:4];
      end
      if (wr_ctrl) begin
         ext_ctrl_d[7] = wb[7];
         ext_ctrl_d[5:3] = wb[5:3];
      end
      if (hw_set[3]) begin
         ext_flags_d[`IRQPF_TIMER3_BIT] = 1'b1;
      end
      if (hw_set[2]) begin
         ext_flags_d[`IRQPF_CONV_BIT] = 1'b1;
      end
      if (hw_set[1]) begin
         ext_flags_d[`IRQPF_TIMER2_BIT] = 1'b1;
      end
      if (hw_set[0]) begin
         ext_flags_d[`IRQPF_RADIO_BIT] = 1'b1;
      end
      if (hw_set[4]) begin
         ext_ctrl_d[`IRQPF_RTC_FLAG_BIT] = 1'b1;
      end
      if (hw_set[5]) begin
         ext_ctrl_d[`IRQPF_FD_FLAG_BIT] = 1'b1;
      end
   end

   // sticky event status, write one to clear, new event wins
   assign stat_d = (stat_q & ~((wr_en & hit_stat) ? wb[5:0] : 6'h00)) | hw_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_flags_q <= `IRQPF_RESET_BYTE;
         ext_ctrl_q <= `IRQPF_RESET_BYTE;
         req_prev_q <= 6'h00;
         stat_q <= 6'h00;
         irq_q <= 1'b0;
      end else begin
         ext_flags_q <= ext_flags_d;
         ext_ctrl_q <= ext_ctrl_d;
         req_prev_q <= hw_lvl;
         stat_q <= stat_d;
         irq_q <= |(stat_d & mask_q);
      end
   end

   // plain software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_en_q <= `IRQPF_RESET_BYTE;
         base_prio_q <= `IRQPF_RESET_BYTE;
         ext_en_q <= `IRQPF_RESET_BYTE;
         ext_prio_q <= `IRQPF_RESET_BYTE;
         sense_q <= 2'h0;
         mask_q <= 6'h00;
      end else if (wr_en) begin
         if (hit_ben) begin
            base_en_q <= wb;
         end else if (hit_bprio) begin
            base_prio_q <= {1'b0, wb[6:0]};
         end else if (hit_een) begin
            ext_en_q <= {3'h0, wb[4:0]};
         end else if (hit_eprio) begin
            ext_prio_q <= {3'h0, wb[4:0]};
         end else if (hit_sense) begin
            sense_q <= wb[1:0];
         end else if (hit_mask) begin
            mask_q <= wb[5:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sources in natural order: 0 flash/debug, 1 ext0, 2 timer0, 3 ext1,
   // 4 timer1, 5 serial0, 6 serial1, 7 radio, 8 timer2, 9 conv/cipher,
   // 10 timer3, 11 rtc
   function automatic irqpf_lvl_t prio_level(input logic bit_set);
      prio_level = bit_set ? `IRQPF_LVL_HIGH : `IRQPF_LVL_LOW;
   endfunction

   wire global_irq_enable = base_en_q[`IRQPF_GLOBAL_BIT];
   wire flashdbg_irq_enable = ext_ctrl_q[`IRQPF_FD_EN_BIT];
   wire [NSRC-1:0] src_req = {ext_ctrl_q[`IRQPF_RTC_FLAG_BIT], ext_flags_q[7:4], serial1_req, serial0_req,
      timer1_req, ext_req[1], timer0_req, ext_req[0], ext_ctrl_q[`IRQPF_FD_FLAG_BIT]};
   wire [NSRC-1:1] src_en = {ext_en_q[4:0], base_en_q[6], base_en_q[4:0]} & {(NSRC-1){global_irq_enable}};
   wire [NSRC-1:1] src_prio = {ext_prio_q[4:0], base_prio_q[6], base_prio_q[4:0]};
   wire [NSRC-1:0] src_pend = src_req & {src_en, flashdbg_irq_enable};

   // level of every source; only source 0 can be top
   irqpf_lvl_t src_lvl [NSRC];
   assign src_lvl[0] = `IRQPF_LVL_TOP;
   genvar g;
   generate
      for (g = 1; g < NSRC; g++) begin : g_lvl
         assign src_lvl[g] = prio_level(src_prio[g]);
      end
   endgenerate

   // level now in service: highest bit set
   wire irqpf_lvl_t cur_lvl = isr_q[3] ? `IRQPF_LVL_TOP : isr_q[2] ? `IRQPF_LVL_HIGH :
      isr_q[1] ? `IRQPF_LVL_LOW : `IRQPF_LVL_NONE;
   // after a return or an enable/priority write one more instruction runs
   wire hold_off = defer_q | (core_instr_done & core_instr_special);

   // best level first, then the lowest number at that level
   irqpf_lvl_t best_lvl;
   irqpf_id_t best_id;
   always_comb begin
      best_lvl = `IRQPF_LVL_NONE;
      best_id = 4'h0;
      for (int i = 0; i < NSRC; i++) begin
         if (src_pend[i] && src_lvl[i] > best_lvl) begin
            best_lvl = src_lvl[i];
         end
      end
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (src_pend[i] && src_lvl[i] == best_lvl) begin
            best_id = irqpf_id_t'(i);
         end
      end
   end

   // presented only when strictly above the level in service
   assign irq_req_d = (best_lvl > cur_lvl) & ~hold_off;
   assign irq_id_d = best_id;
   assign irq_level_d = best_lvl;

   // in-service stack: return drops the top level, acceptance pushes one
   always_comb begin
      isr_d = isr_q;
      if (core_reti && cur_lvl != `IRQPF_LVL_NONE) begin
         isr_d[cur_lvl] = 1'b0;
      end
      if (core_ack && irq_req_q) begin
         isr_d[irq_level_q] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_q <= 1'b0;
         irq_id_q <= 4'h0;
         irq_level_q <= `IRQPF_LVL_NONE;
         isr_q <= 3'h0;
         defer_q <= 1'b0;
      end else begin
         irq_req_q <= irq_req_d & ~(core_ack & irq_req_q); // a taken winner drops for a cycle
         irq_id_q <= irq_id_d;
         irq_level_q <= irq_level_d;
         isr_q <= isr_d;
         if (core_instr_done) begin
            defer_q <= core_instr_special;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign irq_req = irq_req_q;
   assign irq_id = irq_id_q;
   assign irq_level = irq_level_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ext0_low_level;
      (!ext0_pin_n && !sense_q[0]) [*8];
   endsequence

   AST_TIMER3_SET: assert property ($rose(timer3_req) |=> ext_flags_q[7])
      else $error("timer 3 flag not set");
   AST_CONV_SET: assert property ($rose(conv_cipher_req) |=> ext_flags_q[6])
      else $error("converter/cipher flag not set");
   AST_CONV_GATED: assert property ($rose(ext_flags_q[6]) && !$past(wr_flags) |-> $past(conv_cipher_req))
      else $error("shared flag set without enabled source");
   AST_TIMER2_SET: assert property ($rose(timer2_req) |=> ext_flags_q[5])
      else $error("timer 2 flag not set");
   AST_RADIO_SET: assert property ($rose(radio_req) |=> ext_flags_q[4])
      else $error("radio flag not set");
   AST_TOP_ONLY_FD: assert property (irq_req_q && irq_level_q == `IRQPF_LVL_TOP |-> irq_id_q == 4'h0)
      else $error("non flash source at top level");
   AST_PREEMPT: assert property (irq_req_q |-> irq_level_q > $past(cur_lvl))
      else $error("winner not above level in service");
   AST_LEVEL_WINS: assert property (irq_req_q && irq_level_q == `IRQPF_LVL_LOW
      |-> $past((src_pend[NSRC-1:1] & src_prio) == 11'h000 && !src_pend[0]))
      else $error("low level chosen over pending high");
   AST_DEFER: assert property (core_instr_done && core_instr_special |=> !irq_req_q [*2])
      else $error("request presented too soon after special instruction");
   AST_GLOBAL_OFF: assert property (!global_irq_enable |=> !irq_req_q || irq_id_q == 4'h0)
      else $error("source presented with global enable off");
   AST_EXT_PULSE: assert property (s_ext0_low_level |-> ext_req[0])
      else $error("long external pulse missed");

endmodule

// *** irqpf_core_model.sv ***
// core-side partner: accepts the presented winner, promptly or after a wait
// assumes the winner outputs of irqpf_ctrl on the same clock
`timescale 1ns/1ps
module irqpf_core_model
   import irqpf_pkg::*;
(
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic ack_on, // accept winners when high
   input wire logic slow, // hold off three cycles first
   input wire logic irq_req, // winner presented
   input wire irqpf_id_t irq_id, // winning source
   input wire irqpf_lvl_t irq_level, // winning level
   output logic ack_q, // one-cycle accept pulse
   output logic [7:0] acks_q, // accepts so far
   output irqpf_id_t ack_id_q, // source last accepted
   output irqpf_lvl_t ack_lvl_q // level last accepted
);
   logic [1:0] wait_q; // cycles the winner has stood

   ////////////////////////////////////////////////////////////////////////////////
   // accept a standing winner; the pulse drops at once so a stale
   // winner in the following cycle is never taken twice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         acks_q <= 8'h00;
         ack_id_q <= 4'h0;
         ack_lvl_q <= 2'h0;
         wait_q <= 2'h0;
      end else if (ack_q) begin
         ack_q <= 1'b0;
         wait_q <= 2'h0;
      end else if (ack_on && irq_req) begin
         if (!slow || wait_q == 2'h3) begin // slow core only after a wait
            ack_q <= 1'b1;
            acks_q <= acks_q + 8'h01;
            ack_id_q <= irq_id;
            ack_lvl_q <= irq_level;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end else begin
         wait_q <= 2'h0;
      end
   end
endmodule

// *** interrupt_priority_flags_test.sv ***
// self-checking bench for irqpf_ctrl: apb registers, flags, arbitration
// assumes irqpf_core_model stands in for the processor core
`timescale 1ns/1ps
`include "irqpf_params.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module interrupt_priority_flags_test
   import irqpf_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, irq_req;
   logic ack_on, slow, ack, cl_en, cp_en, ext0_n, ext1_n, done, special, reti;
   logic [11:0] paddr; // apb byte address
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] lv; // level requests: timer0, timer1, serial0, serial1
   logic [6:0] ev; // radio, timer2, timer3, rtc, flashdbg, conv, cipher
   irqpf_id_t irq_id, ack_id;
   irqpf_lvl_t irq_level, ack_lvl;
   logic [7:0] acks, bp, ep, fl;
   logic [5:0] w; // expected level and id
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   irqpf_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer0_req(lv[0]), .timer1_req(lv[1]), .serial0_req(lv[2]), .serial1_req(lv[3]),
      .timer2_req(ev[1]), .timer3_req(ev[2]), .radio_req(ev[0]), .rtclock_req(ev[3]),
      .flashdbg_req(ev[4]), .converter_done_flag(ev[5]), .converter_local_enable(cl_en),
      .cipher_done_flag(ev[6]), .cipher_local_enable(cp_en), .ext0_pin_n(ext0_n), .ext1_pin_n(ext1_n),
      .core_ack(ack), .core_reti(reti), .core_instr_done(done), .core_instr_special(special),
      .irq_req(irq_req), .irq_id(irq_id), .irq_level(irq_level), .irq(irq));
   irqpf_core_model core_u (.pclk(pclk), .presetn(presetn), .ack_on(ack_on), .slow(slow),
      .irq_req(irq_req), .irq_id(irq_id), .irq_level(irq_level), .ack_q(ack), .acks_q(acks),
      .ack_id_q(ack_id), .ack_lvl_q(ack_lvl));

   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      `CHK("register", {24'h000000, e}, rd)
   endtask
   // one-cycle event pulses, rising edge sets flags
   task automatic pulse(input logic [6:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 7'h00;
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   task automatic chkwin(input logic r, input logic [3:0] id, input logic [1:0] l);
      `CHK("irq_req", r, irq_req)
      if (r) begin
         `CHK("irq_id", id, irq_id)
         `CHK("irq_level", l, irq_level)
      end
   endtask
   // bounded wait for the core to accept, then compare what it took
   task automatic chkack(input logic [7:0] n, input logic [3:0] id, input logic [1:0] l);
      repeat (40) if (acks !== n) @(posedge pclk);
      `CHK("accept count", n, acks)
      `CHK("accepted id", id, ack_id)
      `CHK("accepted level", l, ack_lvl)
   endtask
   // level first, then lowest natural number; only source 0 is top
   function automatic logic [5:0] exp_win(input logic [11:0] pend, input logic [11:0] hi);
      logic [1:0] best;
      logic [1:0] l;
      logic [3:0] id;
      best = 2'h0;
      id = 4'h0;
      for (int i = 0; i < 12; i++) begin
         l = !pend[i] ? 2'h0 : (i == 0) ? 2'h3 : hi[i] ? 2'h2 : 2'h1;
         if (l > best) begin // strict: ties keep the lower number
            best = l;
            id = i[3:0];
         end
      end
      return {best, id};
   endfunction
   task automatic complete_run();
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin // far beyond the few hundred cycles needed
         num_errors++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, done, special, reti, ack_on, slow, cl_en, cp_en} = '0;
      {paddr, pwdata, lv, ev} = '0;
      {ext0_n, ext1_n} = 2'b11;
      bp = 8'($urandom(11));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`IRQPF_EXT_FLAGS_IDX, 8'h08);
      rdchk(`IRQPF_BASE_PRIO_IDX, 8'h80);
      rdchk(`IRQPF_EXT_PRIO_IDX, 8'he0);
      rdchk(`IRQPF_EXT_CTRL_IDX, 8'h40);
      apb(1'b0, 10'h000, 8'h00);
      `CHK("unmapped error", 1'b1, err)
      // cipher without its own enable must not reach the shared flag
      pulse(7'b1001111);
      rdchk(`IRQPF_EXT_FLAGS_IDX, 8'hb8);
      cl_en <= 1'b1;
      pulse(7'b0100000);
      rdchk(`IRQPF_EXT_FLAGS_IDX, 8'hf8);
      rdchk(`IRQPF_EXT_CTRL_IDX, 8'h48);
      rdchk(`IRQPF_STAT_IDX, 8'h1f);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, `IRQPF_MASK_IDX, 8'h01);
      settle();
      `CHK("irq unmasked", 1'b1, irq)
      apb(1'b1, `IRQPF_STAT_IDX, 8'h01);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      rdchk(`IRQPF_STAT_IDX, 8'h1e);
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h00);
      apb(1'b1, `IRQPF_EXT_CTRL_IDX, 8'h00);
      rdchk(`IRQPF_EXT_FLAGS_IDX, 8'h08);
      // cipher alone, now with its own enable, reaches the shared flag
      cp_en <= 1'b1;
      pulse(7'b1000000);
      rdchk(`IRQPF_EXT_FLAGS_IDX, 8'h48);
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h00);
      // random priorities and requests, two corner cases first
      apb(1'b1, `IRQPF_BASE_EN_IDX, 8'hff);
      apb(1'b1, `IRQPF_EXT_EN_IDX, 8'h1f);
      for (int k = 0; k < 10; k++) begin
         bp = (k < 2) ? 8'h00 : 8'($urandom);
         ep = (k == 1) ? 8'h08 : (k == 0) ? 8'h00 : 8'($urandom);
         fl = (k < 2) ? 8'hf0 : 8'($urandom);
         apb(1'b1, `IRQPF_BASE_PRIO_IDX, bp);
         apb(1'b1, `IRQPF_EXT_PRIO_IDX, ep);
         rdchk(`IRQPF_BASE_PRIO_IDX, bp | 8'h80);
         rdchk(`IRQPF_EXT_PRIO_IDX, ep | 8'he0);
         lv <= fl[3:0];
         apb(1'b1, `IRQPF_EXT_FLAGS_IDX, {fl[7:4], 4'h0});
         settle();
         w = exp_win({1'b0, fl[7:4], fl[3:1], 1'b0, fl[0], 2'b00}, {1'b0, ep[3:0], bp[6], bp[4], bp[3], 1'b0, bp[1], 2'b00});
         chkwin(|fl, w[3:0], w[5:4]);
         lv <= 4'h0;
         apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h00);
      end
      // nesting: equal level waits, higher and top preempt
      apb(1'b1, `IRQPF_BASE_PRIO_IDX, 8'h00);
      apb(1'b1, `IRQPF_EXT_PRIO_IDX, 8'h00);
      ack_on <= 1'b1;
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h10);
      chkack(8'h01, 4'h7, 2'h1);
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h30);
      settle();
      chkack(8'h01, 4'h7, 2'h1);
      slow <= 1'b1;
      apb(1'b1, `IRQPF_EXT_PRIO_IDX, 8'h02);
      chkack(8'h02, 4'h8, 2'h2);
      apb(1'b1, `IRQPF_BASE_EN_IDX, 8'h00);
      apb(1'b1, `IRQPF_EXT_CTRL_IDX, 8'h20);
      pulse(7'b0010000);
      chkack(8'h03, 4'h0, 2'h3);
      ack_on <= 1'b0;
      apb(1'b1, `IRQPF_EXT_CTRL_IDX, 8'h00);
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h10);
      repeat (3) begin
         @(posedge pclk);
         reti <= 1'b1;
         @(posedge pclk);
         reti <= 1'b0;
      end
      // deferral after a special instruction
      apb(1'b1, `IRQPF_BASE_EN_IDX, 8'hff);
      settle();
      chkwin(1'b1, 4'h7, 2'h1);
      done <= 1'b1;
      special <= 1'b1;
      @(posedge pclk);
      done <= 1'b0;
      special <= 1'b0;
      repeat (2) begin
         @(posedge pclk);
         chkwin(1'b0, 4'h0, 2'h0);
      end
      done <= 1'b1;
      @(posedge pclk);
      done <= 1'b0;
      settle();
      chkwin(1'b1, 4'h7, 2'h1);
      apb(1'b1, `IRQPF_EXT_FLAGS_IDX, 8'h00);
      // external pins: pin 0 level, pin 1 falling edge
      apb(1'b1, `IRQPF_SENSE_IDX, 8'h02);
      apb(1'b1, `IRQPF_BASE_EN_IDX, 8'h85);
      ext0_n <= 1'b0;
      repeat (9) @(posedge pclk);
      chkwin(1'b1, 4'h1, 2'h1);
      ext0_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chkwin(1'b0, 4'h0, 2'h0);
      ext1_n <= 1'b0;
      repeat (9) @(posedge pclk);
      ext1_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chkwin(1'b1, 4'h3, 2'h1);
      complete_run();
   end
endmodule
